// [design/ubcm_top.sv]
// Bus cycle break matcher: AXI4-Lite registers, condition match on every
// monitored CPU or DMA bus cycle, and a held break request.
// Assumes the monitor inputs come from logic on core_clk_i.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module ubcm_top
  import ubcm_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // AXI4-Lite write address and data.
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  // AXI4-Lite write response.
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  // AXI4-Lite read.
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  // Monitored bus cycle, one cycle per clock while valid.
  input  wire logic        cycle_valid_i,
  input  wire logic [31:0] cycle_addr_i,
  input  wire logic        cycle_dma_i,
  input  wire logic        cycle_fetch_i,
  input  wire logic        cycle_write_i,
  input  wire logic [1:0]  cycle_size_i,
  // Interrupt controller handshake.
  input  wire logic        brk_accept_i,
  output logic             brk_req_o
);

  import ubcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [15:0] addr_upper_ff, nxt_addr_upper;
  logic [15:0] addr_lower_ff, nxt_addr_lower;
  logic [15:0] mask_upper_ff, nxt_mask_upper;
  logic [15:0] mask_lower_ff, nxt_mask_lower;
  logic [UBCM_SEL_WIDTH-1:0] sel_ff, nxt_sel;
  logic        aw_got_ff, nxt_aw_got;
  logic        w_got_ff,  nxt_w_got;
  logic [7:0]  aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0]  w_strb_ff, nxt_w_strb;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff,  nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff,  nxt_rdata;
  logic [1:0]  rresp_ff,  nxt_rresp;
  logic        hit;
  logic        do_write;
  logic        wr_known;
  logic [31:0] rd_word;
  logic        rd_known;

  // Apply byte strobes to a 16-bit register held in the low half.
  function automatic logic [15:0] ubcm_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : ubcm_merge

  // Tell whether an offset names a register of the map.
  function automatic logic ubcm_known(input logic [7:0] ofs);
    return (ofs == UBCM_OFS_ADDR_UPPER) || (ofs == UBCM_OFS_ADDR_LOWER) ||
           (ofs == UBCM_OFS_MASK_UPPER) || (ofs == UBCM_OFS_MASK_LOWER) ||
           (ofs == UBCM_OFS_CYCLE_SEL)  || (ofs == UBCM_OFS_STATUS);
  endfunction : ubcm_known

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are taken in either order, one at a time.

  assign s_axi_awready_o = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready_o  = !w_got_ff && !bvalid_ff;

  always_comb begin
    nxt_aw_got     = aw_got_ff;
    nxt_w_got      = w_got_ff;
    nxt_aw_addr    = aw_addr_ff;
    nxt_w_data     = w_data_ff;
    nxt_w_strb     = w_strb_ff;
    nxt_bvalid     = bvalid_ff;
    nxt_bresp      = bresp_ff;
    nxt_addr_upper = addr_upper_ff;
    nxt_addr_lower = addr_lower_ff;
    nxt_mask_upper = mask_upper_ff;
    nxt_mask_lower = mask_lower_ff;
    nxt_sel        = sel_ff;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_aw_got  = 1'b1;
      nxt_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_w_got  = 1'b1;
      nxt_w_data = s_axi_wdata_i;
      nxt_w_strb = s_axi_wstrb_i;
    end
    do_write = aw_got_ff && w_got_ff;
    wr_known = ubcm_known(aw_addr_ff);
    if (do_write) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_known ? UBCM_RESP_OKAY : UBCM_RESP_SLVERR;
      unique case (aw_addr_ff)
        UBCM_OFS_ADDR_UPPER: nxt_addr_upper =
          ubcm_merge(addr_upper_ff, w_data_ff, w_strb_ff);
        UBCM_OFS_ADDR_LOWER: nxt_addr_lower =
          ubcm_merge(addr_lower_ff, w_data_ff, w_strb_ff);
        UBCM_OFS_MASK_UPPER: nxt_mask_upper =
          ubcm_merge(mask_upper_ff, w_data_ff, w_strb_ff);
        UBCM_OFS_MASK_LOWER: nxt_mask_lower =
          ubcm_merge(mask_lower_ff, w_data_ff, w_strb_ff);
        // Reserved upper byte is not stored at all.
        UBCM_OFS_CYCLE_SEL: begin
          if (w_strb_ff[0]) begin
            nxt_sel = w_data_ff[7:0];
          end
        end
        default: begin
        end
      endcase
    end else if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one read at a time, answered the cycle after it is taken.

  assign s_axi_arready_o = !rvalid_ff;

  always_comb begin
    rd_known = ubcm_known(s_axi_araddr_i);
    unique case (s_axi_araddr_i)
      UBCM_OFS_ADDR_UPPER: rd_word = {16'h0000, addr_upper_ff};
      UBCM_OFS_ADDR_LOWER: rd_word = {16'h0000, addr_lower_ff};
      UBCM_OFS_MASK_UPPER: rd_word = {16'h0000, mask_upper_ff};
      UBCM_OFS_MASK_LOWER: rd_word = {16'h0000, mask_lower_ff};
      UBCM_OFS_CYCLE_SEL:  rd_word = {24'h000000, sel_ff};
      UBCM_OFS_STATUS:     rd_word = {31'h00000000, brk_req_o};
      default:             rd_word = 32'h00000000;
    endcase
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_word;
      nxt_rresp  = rd_known ? UBCM_RESP_OKAY : UBCM_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
  end

  // Only reset clears the registers; there is no standby clear.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      addr_upper_ff <= UBCM_RST_HALF;
      addr_lower_ff <= UBCM_RST_HALF;
      mask_upper_ff <= UBCM_RST_HALF;
      mask_lower_ff <= UBCM_RST_HALF;
      sel_ff        <= UBCM_RST_CYCLE_SEL[7:0];
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h00000000;
      w_strb_ff     <= 4'h0;
      bvalid_ff     <= 1'b0;
      bresp_ff      <= UBCM_RESP_OKAY;
      rvalid_ff     <= 1'b0;
      rdata_ff      <= 32'h00000000;
      rresp_ff      <= UBCM_RESP_OKAY;
    end else begin
      addr_upper_ff <= nxt_addr_upper;
      addr_lower_ff <= nxt_addr_lower;
      mask_upper_ff <= nxt_mask_upper;
      mask_lower_ff <= nxt_mask_lower;
      sel_ff        <= nxt_sel;
      aw_got_ff     <= nxt_aw_got;
      w_got_ff      <= nxt_w_got;
      aw_addr_ff    <= nxt_aw_addr;
      w_data_ff     <= nxt_w_data;
      w_strb_ff     <= nxt_w_strb;
      bvalid_ff     <= nxt_bvalid;
      bresp_ff      <= nxt_bresp;
      rvalid_ff     <= nxt_rvalid;
      rdata_ff      <= nxt_rdata;
      rresp_ff      <= nxt_rresp;
    end
  end

  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o  = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o  = rdata_ff;
  assign s_axi_rresp_o  = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Match and request. The monitor reports each fetch address separately,
  // so the second word of a paired fetch matches on its own address; the
  // CPU then decides where the exception lands and which PC it saves.

  ubcm_cond u_cond (
    .brk_addr_i    ({addr_upper_ff, addr_lower_ff}),
    .brk_mask_i    ({mask_upper_ff, mask_lower_ff}),
    .sel_i         (sel_ff),
    .cycle_valid_i (cycle_valid_i),
    .cycle_addr_i  (cycle_addr_i),
    .cycle_dma_i   (cycle_dma_i),
    .cycle_fetch_i (cycle_fetch_i),
    .cycle_write_i (cycle_write_i),
    .cycle_size_i  (cycle_size_i),
    .hit_o         (hit)
  );

  ubcm_req u_req (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .set_i      (hit),
    .accept_i   (brk_accept_i),
    .req_o      (brk_req_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_SEL_UPPER_ZERO: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    rvalid_ff && $past(s_axi_araddr_i) == UBCM_OFS_CYCLE_SEL
      && $past(s_axi_arvalid_i) && $past(s_axi_arready_o)
    |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("reserved select bits not zero");
  AST_ZERO_FIELD_NO_HIT: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (sel_ff[7:6] == 2'h0 || sel_ff[5:4] == 2'h0 || sel_ff[3:2] == 2'h0)
    |-> !hit) else $error("hit with a disabled field");
  AST_MASTER: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    hit |-> (cycle_dma_i ? sel_ff[7] : sel_ff[6]))
    else $error("wrong master hit");
  AST_KIND: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    hit |-> (cycle_fetch_i ? sel_ff[4] : sel_ff[5]))
    else $error("wrong kind hit");
  AST_DIR: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    hit |-> (cycle_write_i ? sel_ff[3] : sel_ff[2]))
    else $error("wrong direction hit");
  AST_SIZE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    hit && sel_ff[1:0] != 2'h0 |->
      sel_ff[1:0] == (cycle_fetch_i ? 2'h2 : cycle_size_i))
    else $error("wrong size hit");
  AST_ADDR: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    hit |-> ((cycle_addr_i ^ {addr_upper_ff, addr_lower_ff})
             & ~{mask_upper_ff, mask_lower_ff}) == 32'h0)
    else $error("address mismatch hit");
  // A request may only rise in the cycle after a matching bus cycle.
  AST_REQ_AFTER_HIT: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    $rose(brk_req_o) |-> $past(hit))
    else $error("request without hit");
  AST_SEL_RESET: assert property (@(posedge core_clk_i)
    $fell(resetn_i) |=> sel_ff == 8'h00)
    else $error("select not reset");

endmodule : ubcm_top
`default_nettype wire

// [design/ubcm_pkg.sv]
// Package for the bus cycle break matcher: register map, field layout,
// reset values and bus cycle encodings.
// Assumes an AXI4-Lite register bus with 32-bit data and one clock.
package ubcm_pkg;

  // Register byte offsets on the register bus.
  localparam logic [7:0] UBCM_OFS_ADDR_UPPER = 8'h00;
  localparam logic [7:0] UBCM_OFS_ADDR_LOWER = 8'h04;
  localparam logic [7:0] UBCM_OFS_MASK_UPPER = 8'h08;
  localparam logic [7:0] UBCM_OFS_MASK_LOWER = 8'h0C;
  localparam logic [7:0] UBCM_OFS_CYCLE_SEL  = 8'h10;
  localparam logic [7:0] UBCM_OFS_STATUS     = 8'h14;

  // Reset values.
  localparam logic [15:0] UBCM_RST_HALF      = 16'h0000;
  localparam logic [15:0] UBCM_RST_CYCLE_SEL = 16'h0000;

  // Field positions inside the bus-cycle select register.
  localparam int UBCM_MASTER_MSB = 7;
  localparam int UBCM_MASTER_LSB = 6;
  localparam int UBCM_KIND_MSB   = 5;
  localparam int UBCM_KIND_LSB   = 4;
  localparam int UBCM_DIR_MSB    = 3;
  localparam int UBCM_DIR_LSB    = 2;
  localparam int UBCM_SIZE_MSB   = 1;
  localparam int UBCM_SIZE_LSB   = 0;
  localparam int UBCM_SEL_WIDTH  = 8;

  // Operand size codes, shared by the size field and the bus monitor.
  localparam logic [1:0] UBCM_SIZE_ANY  = 2'h0;
  localparam logic [1:0] UBCM_SIZE_BYTE = 2'h1;
  localparam logic [1:0] UBCM_SIZE_WORD = 2'h2;
  localparam logic [1:0] UBCM_SIZE_LONG = 2'h3;

  // AXI response codes.
  localparam logic [1:0] UBCM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UBCM_RESP_SLVERR = 2'h2;

endpackage : ubcm_pkg

// [design/ubcm_cond.sv]
// Combinational break condition check for one bus cycle.
// Assumes the monitored cycle attributes are stable while cycle_valid_i.
`timescale 1ns/100ps
`default_nettype none
module ubcm_cond
  import ubcm_pkg::*;
(
  // Programmed condition.
  input  wire logic [31:0] brk_addr_i,
  input  wire logic [31:0] brk_mask_i,
  input  wire logic [7:0]  sel_i,
  // Observed bus cycle.
  input  wire logic        cycle_valid_i,
  input  wire logic [31:0] cycle_addr_i,
  input  wire logic        cycle_dma_i,
  input  wire logic        cycle_fetch_i,
  input  wire logic        cycle_write_i,
  input  wire logic [1:0]  cycle_size_i,
  // Result.
  output logic             hit_o
);

  logic [1:0] master_f;
  logic [1:0] kind_f;
  logic [1:0] dir_f;
  logic [1:0] size_f;
  logic [1:0] eff_size;
  logic       addr_ok;
  logic       master_ok;
  logic       kind_ok;
  logic       dir_ok;
  logic       size_ok;

  // Field split and the individual conditions.
  always_comb begin
    master_f  = sel_i[UBCM_MASTER_MSB:UBCM_MASTER_LSB];
    kind_f    = sel_i[UBCM_KIND_MSB:UBCM_KIND_LSB];
    dir_f     = sel_i[UBCM_DIR_MSB:UBCM_DIR_LSB];
    size_f    = sel_i[UBCM_SIZE_MSB:UBCM_SIZE_LSB];
    // Masked bits drop out of the compare.
    addr_ok   = ((brk_addr_i ^ cycle_addr_i) & ~brk_mask_i) == 32'h0;
    // Bit 0 is CPU, bit 1 is DMA; 00 never matches.
    master_ok = cycle_dma_i ? master_f[1] : master_f[0];
    kind_ok   = cycle_fetch_i ? kind_f[0] : kind_f[1];
    dir_ok    = cycle_write_i ? dir_f[1] : dir_f[0];
    // Fetches count as words, even double fetches.
    // Data uses the master's size, not the region width.
    eff_size  = cycle_fetch_i ? UBCM_SIZE_WORD : cycle_size_i;
    size_ok   = (size_f == UBCM_SIZE_ANY) || (size_f == eff_size);
    hit_o     = cycle_valid_i && addr_ok && master_ok && kind_ok && dir_ok
                && size_ok;
  end

endmodule : ubcm_cond
`default_nettype wire

// [design/ubcm_req.sv]
// Break request holder: keeps the request to the interrupt controller
// pending until it is accepted, with set winning over acceptance.
// Assumes accept_i is a one-cycle pulse from the interrupt controller.
`timescale 1ns/100ps
`default_nettype none
module ubcm_req (
  // Clock and reset.
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  // Events.
  input  wire logic set_i,
  input  wire logic accept_i,
  // Request level.
  output logic      req_o
);

  logic req_ff;
  logic nxt_req;

  // A new hit in the acceptance cycle keeps the request alive.
  always_comb begin
    nxt_req = set_i | (req_ff & ~accept_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
    end
  end

  assign req_o = req_ff;

  AST_REQ_HELD: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_o && !accept_i |=> req_o) else $error("request dropped");
  AST_REQ_RELEASE: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    req_o && accept_i && !set_i |=> !req_o)
    else $error("request not released");
  AST_REQ_SET: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    set_i |=> req_o) else $error("hit lost");

endmodule : ubcm_req
`default_nettype wire

// [test/ubcm_interrupt_controller_unit_model.sv]
// Interrupt controller stand-in for the break request path.
// Assumes brk_req_i is a level on core_clk_i; mask_level_i is set by
// the bench to stall or free the acceptance.
`timescale 1ns/100ps
`default_nettype none
module ubcm_irq_model (
  // Clock and reset.
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  // Request and processor mask level.
  input  wire logic       brk_req_i,
  input  wire logic [3:0] mask_level_i,
  // Acceptance pulse.
  output logic            accept_o
);
  logic accept_ff;
  logic nxt_accept;

  ////////////////////////////////////////////////////////////////////////
  // Priority 15 is taken only below level 15. The pulse is not repeated
  // because the request needs one cycle to fall after acceptance.
  always_comb begin
    nxt_accept = brk_req_i && (mask_level_i <= 4'hE) && !accept_ff;
  end

  // Plain register stage, cleared by reset.
  always_ff @(posedge core_clk_i) begin
    accept_ff <= resetn_i ? nxt_accept : 1'b0;
  end

  assign accept_o = accept_ff;
endmodule : ubcm_irq_model
`default_nettype wire

// [test/ubcm_top_test.sv]
// Self-checking bench for the bus cycle break matcher.
// Assumes the interrupt controller stand-in answers the break request.
`timescale 1ns/100ps
`default_nettype none
module ubcm_top_test;
  import ubcm_pkg::*;
  // Bench drive.
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        cvalid = 1'b0;
  logic [31:0] caddr = 32'h0;
  logic [4:0]  ctype = 5'h00;
  logic [3:0]  lvl = 4'hF;
  // Design answers.
  logic        awready, wready, bvalid, arready, rvalid, req, acc;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          errors = 0;
  int          comparisons = 0;
  int          accepts = 0;

  ////////////////////////////////////////////////////////////////////////
  // Design and far side. Write strobes stay full: the 16-bit registers
  // would otherwise keep stale bytes.
  ubcm_top dut_u (
    .core_clk_i      (clk),
    .resetn_i        (rst_n),
    .s_axi_awvalid_i (awvalid),
    .s_axi_awready_o (awready),
    .s_axi_awaddr_i  (awaddr),
    .s_axi_wvalid_i  (wvalid),
    .s_axi_wready_o  (wready),
    .s_axi_wdata_i   (wdata),
    .s_axi_wstrb_i   (4'hF),
    .s_axi_bvalid_o  (bvalid),
    .s_axi_bready_i  (bready),
    .s_axi_bresp_o   (bresp),
    .s_axi_arvalid_i (arvalid),
    .s_axi_arready_o (arready),
    .s_axi_araddr_i  (araddr),
    .s_axi_rvalid_o  (rvalid),
    .s_axi_rready_i  (rready),
    .s_axi_rdata_o   (rdata),
    .s_axi_rresp_o   (rresp),
    .cycle_valid_i   (cvalid),
    .cycle_addr_i    (caddr),
    .cycle_dma_i     (ctype[4]),
    .cycle_fetch_i   (ctype[3]),
    .cycle_write_i   (ctype[2]),
    .cycle_size_i    (ctype[1:0]),
    .brk_accept_i    (acc),
    .brk_req_o       (req)
  );
  ubcm_irq_model irq_u (
    .core_clk_i   (clk),
    .resetn_i     (rst_n),
    .brk_req_i    (req),
    .mask_level_i (lvl),
    .accept_o     (acc)
  );

  // Clock and acceptance counter.
  always #12.5 clk = ~clk;
  always @(posedge clk) if (acc === 1'b1) accepts++;

  ////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and hang handling.
  task automatic print_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic hang(input string what);
    errors++;
    $display("[FAIL] %s expected answer seen timeout", what);
    print_verdict();
  endtask : hang

  ////////////////////////////////////////////////////////////////////////
  // Register bus master. Values are sampled before the edge's updates.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    bit aw_done = 1'b0;
    bit w_done = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    if (!(aw_done && w_done)) hang("write accept");
    for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge clk);
    if (n == 50) hang("write response");
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (n = 0; n < 50 && rvalid !== 1'b1; n++) begin
      @(posedge clk);
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
    end
    if (n == 50) hang("read response");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Expected match of one cycle, t = {dma, fetch, write, size}.
  function automatic logic hit_exp(input logic [7:0] s, input logic [4:0] t);
    logic [1:0] sz;
    sz = t[3] ? UBCM_SIZE_WORD : t[1:0];
    return (t[4] ? s[7] : s[6]) && (t[3] ? s[4] : s[5]) &&
           (t[2] ? s[3] : s[2]) &&
           (s[1:0] == UBCM_SIZE_ANY || s[1:0] == sz);
  endfunction : hit_exp

  // One monitored cycle; a raised request is held, then freed once.
  task automatic cyc(input logic [31:0] a, input logic [4:0] t,
                     input logic exp, input int hold);
    int          n;
    int          a0;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    cvalid <= 1'b1;
    caddr  <= a;
    ctype  <= t;
    @(posedge clk);
    cvalid <= 1'b0;
    @(negedge clk);
    chk("break request", req, exp);
    if (hold > 0) begin
      repeat (hold) @(posedge clk);
      axi_rd(UBCM_OFS_STATUS, d, r);
      chk("pending request", d, 32'h1);
    end
    if (req === 1'b1) begin
      a0 = accepts;
      @(posedge clk);
      lvl <= 4'h0;
      for (n = 0; n < 20 && req !== 1'b0; n++) @(negedge clk);
      if (n == 20) hang("request release");
      chk("accepts per match", accepts - a0, 1);
      @(posedge clk);
      lvl <= 4'hF;
    end
  endtask : cyc

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic sc_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(UBCM_OFS_CYCLE_SEL, d, r);
    chk("select reset value", d, 32'h0);
    axi_wr(UBCM_OFS_CYCLE_SEL, 32'h0000_00C3, r);
    axi_rd(UBCM_OFS_CYCLE_SEL, d, r);
    chk("select readback", d, 32'h0000_00C3);
    axi_wr(8'h18, 32'h0000_00FF, r);
    chk("unmapped write response", r, UBCM_RESP_SLVERR);
    axi_rd(8'h18, d, r);
    chk("unmapped read data", d, 32'h0);
    chk("unmapped read response", r, UBCM_RESP_SLVERR);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(UBCM_OFS_CYCLE_SEL, d, r);
    chk("select after reset", d, 32'h0);
  endtask : sc_regs

  task automatic sc_address;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(UBCM_OFS_ADDR_UPPER, 32'h0000_1234, r);
    axi_wr(UBCM_OFS_ADDR_LOWER, 32'h0000_5678, r);
    axi_wr(UBCM_OFS_MASK_LOWER, 32'h0000_00F0, r);
    axi_wr(UBCM_OFS_CYCLE_SEL, 32'h0000_00FC, r);
    axi_rd(UBCM_OFS_ADDR_UPPER, d, r);
    chk("address upper", d, 32'h0000_1234);
    cyc(32'h1234_5678, 5'h01, 1'b1, 0);
    cyc(32'h1234_56F8, 5'h01, 1'b1, 0);
    cyc(32'h1234_5679, 5'h01, 1'b0, 0);
    cyc(32'h1235_5678, 5'h01, 1'b0, 0);
    axi_wr(UBCM_OFS_MASK_UPPER, 32'h0000_0001, r);
    cyc(32'h1235_5678, 5'h01, 1'b1, 0);
    axi_wr(UBCM_OFS_MASK_UPPER, 32'h0000_0000, r);
    cyc(32'h1234_5678, 5'h01, 1'b1, 30);
  endtask : sc_address

  // Every select value except fetch-only kind with byte or long size, against every cycle kind and operand size.
  task automatic sc_fields;
    logic [1:0] r;
    for (int i = 0; i < 256; i++) begin
      if (i[5:4] == 2'b01 && i[0]) continue;
      axi_wr(UBCM_OFS_CYCLE_SEL, i, r);
      for (int j = 0; j < 32; j++) begin
        if (j[1:0] == 2'b00) continue;
        cyc(32'h1234_5678, j[4:0], hit_exp(i[7:0], j[4:0]), 0);
      end
    end
  endtask : sc_fields

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    sc_regs();
    sc_address();
    sc_fields();
    print_verdict();
  end
endmodule : ubcm_top_test
`default_nettype wire
